// file: inc/ppb_params.svh
// constants for the programming port boot control block
// assumes a single 20 MHz system clock and asynchronous active-high reset
`ifndef PPB_PARAMS_SVH
`define PPB_PARAMS_SVH
// clock rate in MHz, period 50 ns
`define PPB_CLK_MHZ 20
// diagnostic poll period in microseconds
`define PPB_POLL_PERIOD_US 1000
// poll period in clock cycles, derived from the rate
`define PPB_POLL_CYCLES (`PPB_POLL_PERIOD_US * `PPB_CLK_MHZ)
// cycles after reset release before boot selects are judged
`define PPB_SENSE_DELAY 3
// cycles the raised transmit line must settle before loop test
`define PPB_LOOP_SETTLE 3
// bits per clocked serial character
`define PPB_SER_BITS 8
// number of pins passed through the synchroniser
`define PPB_SYNC_W 4
// synchroniser bit positions
`define PPB_SYNC_RX 0
`define PPB_SYNC_CLK 1
`define PPB_SYNC_BS0 2
`define PPB_SYNC_BS1 3
`endif

// file: inc/ppb_pkg.sv
// types for the programming port boot control block
// assumes ppb_params.svh supplies the numeric constants
package ppb_pkg;
  // boot select sensing sequence after reset
  typedef enum logic {
    PPB_SENSE_WAIT = 1'b0,
    PPB_SENSE_RUN = 1'b1
  } ppb_sense_type;
endpackage : ppb_pkg

// file: inc/ppb_sync_if.sv
// carrier between the port logic and its pin synchroniser
// assumes both ends run on clk_sys
interface ppb_sync_if #(parameter int W = 4);
  logic [W-1:0] raw; // pin levels straight from the pads
  logic [W-1:0] synced; // levels after two flip-flops
  modport sync_side (input raw, output synced);
  modport user (output raw, input synced);
endinterface : ppb_sync_if

// file: core/ppb_sync.sv
// two flip-flop synchroniser for the port's input pins
// assumes pins are asynchronous to clk_sys
module ppb_sync
  import ppb_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  ppb_sync_if.sync_side sif
);
  logic [W-1:0] stage1_ff; // read only by stage2_ff
  logic [W-1:0] stage2_ff; // safe to use
  logic [W-1:0] nxt_stage1;
  logic [W-1:0] nxt_stage2;

  // next values: plain shift
  always_comb begin
    nxt_stage1 = sif.raw;
    nxt_stage2 = stage1_ff;
  end

  // registers; reset low matches the strap low level
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign sif.synced = stage2_ff;
endmodule : ppb_sync

// file: core/ppb_programming_connector_port.sv
// programming port pin logic: boot select sensing, transmit line
// control, loop cable test, diagnostic attention, clocked serial
// and general I/O remap
// assumes control inputs come from core logic on clk_sys and that
// outside circuitry keeps boot selects low at reset in I/O use
`include "ppb_params.svh"
module ppb_programming_connector_port
  import ppb_pkg::*;
#(
  parameter int POLL_CYCLES = `PPB_POLL_CYCLES,
  parameter int SER_BITS = `PPB_SER_BITS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serialAReceive,
  input wire logic serialAClock,
  input wire logic bootSelect0,
  input wire logic bootSelect1,
  input wire logic coldBootEn,
  input wire logic genIoEn,
  input wire logic portC6GenOut,
  input wire logic portC6Value,
  input wire logic uartTxBit,
  input wire logic clockedModeEn,
  input wire logic diagPollEn,
  input wire logic diagIntEn,
  input wire logic statusLevel,
  input wire logic [SER_BITS-1:0] txData,
  input wire logic txLoad,
  output logic serialATransmit,
  output logic statusPin,
  output logic cableAttached,
  output logic loopDetected,
  output logic [1:0] bootSelLevels,
  output logic portC7In,
  output logic portB1In,
  output logic diagAttention,
  output logic [SER_BITS-1:0] rxByte,
  output logic rxByteValid
);
  localparam int POLL_W = $clog2(POLL_CYCLES);
  localparam int CNT_W = $clog2(SER_BITS);

  ppb_sync_if #(.W(`PPB_SYNC_W)) syncBus ();
  logic [`PPB_SYNC_W-1:0] pinSync; // synchronised pin levels

  // all four pins pass two flip-flops before use
  ppb_sync #(.W(`PPB_SYNC_W)) ppb_sync_i (
    .clk_sys(clk_sys),
    .reset(reset),
    .sif(syncBus.sync_side)
  );
  assign syncBus.raw = {bootSelect1, bootSelect0, serialAClock,
                        serialAReceive};
  assign pinSync = syncBus.synced;

  // control group state
  ppb_sense_type sense_ff, nxt_sense; // boot select sensing
  logic [1:0] senseCnt_ff, nxt_senseCnt; // wait after release
  logic cable_ff, nxt_cable; // cable judged present
  logic tx_ff, nxt_tx; // transmit pin
  logic status_ff, nxt_status; // status pin
  logic [1:0] settle_ff, nxt_settle; // loop settle count
  logic loop_ff, nxt_loop; // loop found
  logic [1:0] bootLvl_ff, nxt_bootLvl; // select levels view
  logic c7_ff, nxt_c7; // receive as port C bit 7
  logic b1_ff, nxt_b1; // clock as port B bit 1
  logic [POLL_W-1:0] poll_ff, nxt_poll; // poll interval
  logic diagnostic_connector_ff, nxt_diagnostic_connector; // attention pulse
  // outgoing clocked serial bits; declared here because the transmit
  // mux below reads the top bit
  logic [SER_BITS-1:0] txShift_ff, nxt_txShift;
  logic loopDrive; // loop test forcing transmit high
  logic pollTick; // end of poll interval

  // control group next values
  always_comb begin
    nxt_sense = sense_ff;
    nxt_senseCnt = senseCnt_ff;
    nxt_cable = cable_ff;
    // judged once; later changes of the selects are ignored
    unique case (sense_ff)
      PPB_SENSE_WAIT: begin
        if (senseCnt_ff == 2'(`PPB_SENSE_DELAY - 1)) begin
          nxt_cable = pinSync[`PPB_SYNC_BS0] && pinSync[`PPB_SYNC_BS1];
          nxt_sense = PPB_SENSE_RUN;
        end else begin
          nxt_senseCnt = senseCnt_ff + 2'h1;
        end
      end
      PPB_SENSE_RUN: begin
        nxt_senseCnt = senseCnt_ff;
      end
    endcase
    // transmit source, general I/O first
    loopDrive = portC6GenOut && !coldBootEn && !genIoEn;
    if (genIoEn) begin
      nxt_tx = portC6Value;
    end else if (loopDrive) begin
      nxt_tx = 1'b1;
    end else if (clockedModeEn) begin
      nxt_tx = txShift_ff[SER_BITS-1];
    end else if (coldBootEn) begin
      nxt_tx = uartTxBit;
    end else begin
      nxt_tx = 1'b0;
    end
    // status is an output in every mode
    nxt_status = statusLevel;
    // loop test waits for the raised line to settle at the select
    if (loopDrive && tx_ff) begin
      nxt_settle = (settle_ff == 2'(`PPB_LOOP_SETTLE)) ? settle_ff
                   : settle_ff + 2'h1;
    end else begin
      nxt_settle = 2'h0;
    end
    nxt_loop = loopDrive && tx_ff && pinSync[`PPB_SYNC_BS0]
               && (settle_ff == 2'(`PPB_LOOP_SETTLE));
    nxt_bootLvl = {pinSync[`PPB_SYNC_BS1], pinSync[`PPB_SYNC_BS0]};
    nxt_c7 = genIoEn && pinSync[`PPB_SYNC_RX];
    nxt_b1 = genIoEn && pinSync[`PPB_SYNC_CLK];
    // poll interval runs only while polling is chosen
    pollTick = (poll_ff == POLL_W'(POLL_CYCLES - 1));
    if (!diagPollEn || pollTick) begin
      nxt_poll = '0;
    end else begin
      nxt_poll = poll_ff + POLL_W'(1);
    end
    // idle line is high; a low level means traffic has started
    nxt_diagnostic_connector = !genIoEn && !pinSync[`PPB_SYNC_RX]
               && (diagIntEn || (diagPollEn && pollTick));
  end

  // control group registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sense_ff <= PPB_SENSE_WAIT;
      senseCnt_ff <= 2'h0;
      cable_ff <= 1'b0;
      tx_ff <= 1'b0;
      status_ff <= 1'b0;
      settle_ff <= 2'h0;
      loop_ff <= 1'b0;
      bootLvl_ff <= 2'h0;
      c7_ff <= 1'b0;
      b1_ff <= 1'b0;
      poll_ff <= '0;
      diagnostic_connector_ff <= 1'b0;
    end else begin
      sense_ff <= nxt_sense;
      senseCnt_ff <= nxt_senseCnt;
      cable_ff <= nxt_cable;
      tx_ff <= nxt_tx;
      status_ff <= nxt_status;
      settle_ff <= nxt_settle;
      loop_ff <= nxt_loop;
      bootLvl_ff <= nxt_bootLvl;
      c7_ff <= nxt_c7;
      b1_ff <= nxt_b1;
      poll_ff <= nxt_poll;
      diagnostic_connector_ff <= nxt_diagnostic_connector;
    end
  end

  // clocked serial group state
  logic clkHist_ff, nxt_clkHist; // previous synced clock
  logic [SER_BITS-1:0] rxShift_ff, nxt_rxShift; // incoming bits
  logic [CNT_W-1:0] bitCnt_ff, nxt_bitCnt; // bits received
  logic [SER_BITS-1:0] rxByte_ff, nxt_rxByte; // last character
  logic rxValid_ff, nxt_rxValid; // one-cycle strobe
  logic clkRise; // partner clock rose: sample receive
  logic clkFall; // partner clock fell: present next bit

  // clocked serial next values; partner drives clock and data
  always_comb begin
    clkRise = pinSync[`PPB_SYNC_CLK] && !clkHist_ff;
    clkFall = !pinSync[`PPB_SYNC_CLK] && clkHist_ff;
    nxt_clkHist = pinSync[`PPB_SYNC_CLK];
    nxt_rxShift = rxShift_ff;
    nxt_txShift = txShift_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_rxByte = rxByte_ff;
    nxt_rxValid = 1'b0;
    if (!clockedModeEn || genIoEn) begin
      nxt_bitCnt = '0; // leaving the mode drops a partial character
    end else if (clkRise) begin
      nxt_rxShift = {rxShift_ff[SER_BITS-2:0], pinSync[`PPB_SYNC_RX]};
      if (bitCnt_ff == CNT_W'(SER_BITS - 1)) begin
        nxt_rxByte = {rxShift_ff[SER_BITS-2:0], pinSync[`PPB_SYNC_RX]};
        nxt_rxValid = 1'b1;
        nxt_bitCnt = '0;
      end else begin
        nxt_bitCnt = bitCnt_ff + CNT_W'(1);
      end
    end
    // a load wins over a shift in the same cycle
    if (txLoad) begin
      nxt_txShift = txData;
    end else if (clockedModeEn && clkFall) begin
      nxt_txShift = {txShift_ff[SER_BITS-2:0], 1'b1};
    end
  end

  // clocked serial registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clkHist_ff <= 1'b0;
      rxShift_ff <= '0;
      txShift_ff <= '0;
      bitCnt_ff <= '0;
      rxByte_ff <= '0;
      rxValid_ff <= 1'b0;
    end else begin
      clkHist_ff <= nxt_clkHist;
      rxShift_ff <= nxt_rxShift;
      txShift_ff <= nxt_txShift;
      bitCnt_ff <= nxt_bitCnt;
      rxByte_ff <= nxt_rxByte;
      rxValid_ff <= nxt_rxValid;
    end
  end

  // outputs straight from flip-flops
  assign serialATransmit = tx_ff;
  assign statusPin = status_ff;
  assign cableAttached = cable_ff;
  assign loopDetected = loop_ff;
  assign bootSelLevels = bootLvl_ff;
  assign portC7In = c7_ff;
  assign portB1In = b1_ff;
  assign diagAttention = diagnostic_connector_ff;
  assign rxByte = rxByte_ff;
  assign rxByteValid = rxValid_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  status_follow_a: assert property (
    ##1 statusPin == $past(statusLevel))
    else $error("status pin does not follow status level");
  cable_sense_a: assert property (
    sense_ff == PPB_SENSE_WAIT && senseCnt_ff == 2'h2 |=>
    cableAttached == $past(pinSync[2] && pinSync[3]))
    else $error("cable detection wrong at boot sense");
  cable_hold_a: assert property (
    sense_ff == PPB_SENSE_RUN |=> $stable(cableAttached))
    else $error("cable flag changed after boot sense");
  diagnostic_connector_cause_a: assert property (
    diagAttention |-> $past(!pinSync[0] && !genIoEn
      && (diagIntEn || (diagPollEn && pollTick))))
    else $error("diagnostic attention without cause");
  serial_byte_a: assert property (
    rxByteValid |-> $past(clkRise && clockedModeEn)
    && rxByte == $past({rxShift_ff[SER_BITS-2:0], pinSync[0]}))
    else $error("clocked serial byte without clock rise");
  tx_zero_a: assert property (
    !coldBootEn && !genIoEn && !portC6GenOut && !clockedModeEn
    |=> !serialATransmit)
    else $error("transmit not low without cold boot");
  loop_drive_a: assert property (
    loopDrive [*2] |=> serialATransmit)
    else $error("loop test did not raise transmit");
  loop_found_a: assert property (
    loopDetected |-> $past(serialATransmit, 1) && $past(pinSync[2]))
    else $error("loop found without raised transmit");
  // the synchroniser is held clear in reset, so the view only tracks
  // the pins three edges back once boot sensing has finished
  bootsel_view_a: assert property (
    sense_ff == PPB_SENSE_RUN
    |-> bootSelLevels == $past({bootSelect1, bootSelect0}, 3))
    else $error("boot select levels wrong");
  genio_map_a: assert property (
    genIoEn && $past(genIoEn) |=> portC7In == $past(pinSync[0])
    && portB1In == $past(pinSync[1]) && serialATransmit == $past(portC6Value))
    else $error("general I/O mapping wrong");

  cable_seen_c: cover property (sense_ff == PPB_SENSE_RUN && cableAttached);
  loop_seen_c: cover property (loopDetected);
  byte_seen_c: cover property (rxByteValid);
  diagnostic_connector_seen_c: cover property (diagAttention && diagPollEn && !diagIntEn);
endmodule : ppb_programming_connector_port

// file: test/ppb_host_model.sv
// host side of the programming cable: selects, loop wire, clocked serial
// assumes the device samples receive on clock rise and shifts on fall
module ppb_host_model (
  input wire logic clk_sys,
  input wire logic serialATransmit,
  input wire logic sel0Req,
  input wire logic sel1Req,
  input wire logic loopOn,
  output logic bootSelect0,
  output logic bootSelect1,
  output logic serialAClock,
  output logic serialAReceive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] txSeen; // character sensed on transmit, msb first
  // loop cable ties select 0 to transmit, else selects follow the host
  always_comb begin
    bootSelect1 = sel1Req;
    bootSelect0 = loopOn ? serialATransmit : sel0Req;
  end
  // pull-ups keep clock and receive high outside frames
  initial begin
    serialAClock = 1'b1;
    serialAReceive = 1'b1;
    txSeen = 8'h00;
  end
  // two driven toggling lines and one sensed line
  task automatic send_byte(input logic [7:0] b, input int half);
    for (int i = 7; i >= 0; i--) begin
      repeat (half) @(posedge clk_sys);
      #2 txSeen[i] = serialATransmit; // sense before the shift edge
      serialAClock = 1'b0;
      serialAReceive = b[i];
      repeat (half) @(posedge clk_sys);
      #2 serialAClock = 1'b1; // device samples on this rise
    end
    // hold the last bit past the sample point before releasing
    repeat (half) @(posedge clk_sys);
    #2 serialAReceive = 1'b1;
  endtask : send_byte
endmodule : ppb_host_model

// file: test/programming_port_boot_control_tb.sv
// self-checking bench for the programming port pin logic
// assumes one 20 MHz clock and the host model on the far side
module programming_port_boot_control_tb;
  import ppb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POLL = 16; // shortened poll period
  logic clk_sys, reset, coldBootEn, genIoEn, portC6GenOut, portC6Value;
  logic uartTxBit, clockedModeEn, diagPollEn, diagIntEn, statusLevel;
  logic txLoad, serialATransmit, statusPin, cableAttached, loopDetected;
  logic portC7In, portB1In, diagAttention, rxByteValid;
  logic bootSelect0, bootSelect1, serialAClock, serialAReceive;
  logic sel0Req, sel1Req, loopOn;
  logic [7:0] txData, rxByte, b;
  logic [1:0] bootSelLevels;
  logic [31:0] seed, r, cnt, nValid;
  int n_fail, num_checks;
  ppb_programming_connector_port #(.POLL_CYCLES(POLL), .SER_BITS(8)) ppb_programming_connector_port_i (
    .clk_sys(clk_sys), .reset(reset), .serialAReceive(serialAReceive),
    .serialAClock(serialAClock), .bootSelect0(bootSelect0),
    .bootSelect1(bootSelect1), .coldBootEn(coldBootEn), .genIoEn(genIoEn),
    .portC6GenOut(portC6GenOut), .portC6Value(portC6Value),
    .uartTxBit(uartTxBit), .clockedModeEn(clockedModeEn),
    .diagPollEn(diagPollEn), .diagIntEn(diagIntEn),
    .statusLevel(statusLevel), .txData(txData), .txLoad(txLoad),
    .serialATransmit(serialATransmit), .statusPin(statusPin),
    .cableAttached(cableAttached), .loopDetected(loopDetected),
    .bootSelLevels(bootSelLevels), .portC7In(portC7In),
    .portB1In(portB1In), .diagAttention(diagAttention), .rxByte(rxByte),
    .rxByteValid(rxByteValid));
  ppb_host_model host_i (
    .clk_sys(clk_sys), .serialATransmit(serialATransmit),
    .sel0Req(sel0Req), .sel1Req(sel1Req), .loopOn(loopOn),
    .bootSelect0(bootSelect0), .bootSelect1(bootSelect1),
    .serialAClock(serialAClock), .serialAReceive(serialAReceive));
  // 50 ns period clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // count completed characters so a one-cycle pulse is never missed
  // cleared by reset so the counter has a single driver
  always @(posedge clk_sys) begin
    if (reset === 1'b1) nValid <= 32'h0;
    else if (rxByteValid === 1'b1) nValid <= nValid + 32'h1;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // pulses seen in a window of back-to-back poll periods
  function automatic logic [31:0] poll_pulses(input int win);
    return 32'(win / POLL);
  endfunction : poll_pulses
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // inputs always move the same small delay after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  // pulse reset while the host holds the boot selects at the given levels
  task automatic do_reset(input logic s0, input logic s1);
    reset = 1'b1;
    sel0Req = s0;
    sel1Req = s1;
    tick(2);
    check(serialATransmit, 0);
    reset = 1'b0;
    tick(5);
  endtask : do_reset
  // counts attention pulses over a window of cycles
  task automatic count_attn(input int win);
    cnt = 0;
    for (int i = 0; i < win; i++) begin
      tick(1);
      if (diagAttention === 1'b1) cnt++;
    end
  endtask : count_attn
  initial begin
    {coldBootEn, genIoEn, portC6GenOut, portC6Value, uartTxBit} = '0;
    {clockedModeEn, diagPollEn, diagIntEn, statusLevel, txLoad} = '0;
    {loopOn, txData, n_fail, num_checks} = '0;
    seed = 32'hEC59;
    do_reset(1'b1, 1'b1);
    check(cableAttached, 1);
    check(serialATransmit, 0);
    do_reset(1'b0, 1'b0); // outside logic keeps selects low
    check(cableAttached, 0);
    for (int i = 0; i < 6; i++) begin
      r = xs();
      statusLevel = r[0];
      sel0Req = r[1];
      sel1Req = r[2];
      tick(1);
      check(statusPin, r[0]);
      tick(3);
      check(bootSelLevels, r[2:1]);
      check(cableAttached, 0);
    end
    {sel0Req, sel1Req} = 2'b00;
    coldBootEn = 1'b1;
    portC6GenOut = 1'b1; // cold boot must override the loop drive
    for (int i = 0; i < 4; i++) begin
      r = xs();
      uartTxBit = r[0];
      tick(2);
      check(serialATransmit, uartTxBit);
    end
    loopOn = 1'b1;
    coldBootEn = 1'b0;
    tick(7);
    check(serialATransmit, 1);
    check(loopDetected, 1);
    portC6GenOut = 1'b0;
    tick(4);
    check(serialATransmit, 0);
    check(loopDetected, 0);
    loopOn = 1'b0;
    host_i.serialAReceive = 1'b0;
    diagPollEn = 1'b1;
    tick(4);
    count_attn(3 * POLL);
    check(cnt, poll_pulses(3 * POLL));
    diagPollEn = 1'b0;
    diagIntEn = 1'b1;
    tick(2);
    count_attn(8);
    check(cnt, 8);
    genIoEn = 1'b1;
    tick(3);
    count_attn(8);
    check(cnt, 0);
    for (int i = 0; i < 6; i++) begin
      r = xs();
      portC6Value = r[0];
      host_i.serialAReceive = r[1];
      host_i.serialAClock = r[2];
      tick(4);
      check(serialATransmit, r[0]);
      check({portB1In, portC7In}, r[2:1]);
    end
    // idle lines settle through the synchroniser before the mode starts,
    // else a low clock left by the I/O phase would count as a rise
    host_i.serialAReceive = 1'b1;
    host_i.serialAClock = 1'b1;
    tick(4);
    {genIoEn, diagIntEn} = 2'b00;
    clockedModeEn = 1'b1;
    tick(4);
    for (int k = 0; k < 6; k++) begin
      // boot restart string first, then random characters
      b = (k == 1) ? 8'h24 : (k < 3) ? 8'h80 : 8'(xs());
      txData = 8'(xs());
      txLoad = 1'b1;
      tick(1);
      txLoad = 1'b0;
      host_i.send_byte(b, 4);
      tick(4);
      check(nValid, k + 1);
      check(rxByte, b);
      check(host_i.txSeen, txData);
    end
    print_verdict();
  end
  // cut a hang short well beyond the expected run length
  initial begin
    #2000000;
    n_fail++;
    print_verdict();
  end
endmodule : programming_port_boot_control_tb
